// ### src/lfs_pkg.sv
package lfs_pkg;
   localparam int ADDR_W      = 8;
   localparam int DATA_W      = 32;
   localparam int LINE_HIGH_N = 16;
   localparam int LINE_LOW_N  = 48;
   localparam int CH_N        = 48;
   localparam int LINE_N      = 64;
   localparam int LO_W        = 32;
   localparam int HI_W        = 16;
   localparam int SEL_W       = 6;
   localparam int IRQ_W       = 4;

   // register word offsets (byte addresses, one aligned word each)
   localparam logic [ADDR_W-1:0] ADDR_LINE_HIGH    = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_LINE_LOW_LO  = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_LINE_LOW_HI  = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_OPEN_LO      = 8'h0c;
   localparam logic [ADDR_W-1:0] ADDR_OPEN_HI      = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_SHORT_LO     = 8'h14;
   localparam logic [ADDR_W-1:0] ADDR_SHORT_HI     = 8'h18;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS   = 8'h1c;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK     = 8'h20;
   localparam logic [ADDR_W-1:0] ADDR_LINE_SELECT  = 8'h24;

   // interrupt status and mask bit positions
   localparam int IRQ_LINE_HIGH = 0;
   localparam int IRQ_LINE_LOW  = 1;
   localparam int IRQ_OPEN      = 2;
   localparam int IRQ_SHORT     = 3;

   localparam logic [IRQ_W-1:0]  IRQ_RESET    = 4'h0;
   localparam logic [SEL_W-1:0]  SEL_RESET    = 6'h00;
   localparam logic [DATA_W-1:0] DATA_RESET   = 32'h0000_0000;
endpackage

// ### src/lfs_flag_track.sv
`timescale 1ns/1ps
module lfs_flag_track #(
   parameter int WIDTH = 48
) (
   input  wire logic             clk,
   input  wire logic             rstSyncN,
   input  wire logic [WIDTH-1:0] flags,
   output logic      [WIDTH-1:0] mirror,
   output logic                  newFault
);
   logic [WIDTH-1:0] rising;

   // per-bit snapshot so register reads come from a flip-flop; the edge detect reads flags live
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk or negedge rstSyncN) begin
            if (!rstSyncN) begin
               mirror[i] <= 1'b0;
            end else begin
               mirror[i] <= flags[i];
            end
         end
         assign rising[i] = flags[i] & ~mirror[i];
      end
   endgenerate

   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         newFault <= 1'b0;
      end else begin
         newFault <= |rising;
      end
   end
endmodule // lfs_flag_track

// ### src/lfs_fault_regs.sv
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module lfs_fault_regs
   import lfs_pkg::*;
(
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [lfs_pkg::ADDR_W-1:0] paddr,
   input  wire logic [lfs_pkg::DATA_W-1:0] pwdata,
   output logic      [lfs_pkg::DATA_W-1:0] prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic [lfs_pkg::LINE_N-1:0] lineShortFlags,
   input  wire logic [lfs_pkg::CH_N-1:0]   channelOpenFlags,
   input  wire logic [lfs_pkg::CH_N-1:0]   channelShortFlags,
   output logic      [lfs_pkg::SEL_W-1:0]  shortLineSelect,
   output logic                          irq
);
   import lfs_pkg::*;

   logic                   rstMeta;
   logic                   rstSyncN;
   logic [LINE_N-1:0]      lineMirror;
   logic [CH_N-1:0]        openMirror;
   logic [CH_N-1:0]        shortMirror;
   logic [IRQ_W-1:0]       faultEvent;
   logic [IRQ_W-1:0]       irqStatus;
   logic [IRQ_W-1:0]       irqMask;
   logic [IRQ_W-1:0]       statusClear;
   logic [DATA_W-1:0]      rdValue;
   logic                   addrHit;
   logic                   setupPhase;
   logic                   accessDone;
   logic                   statusRead;

   // reset enters at once and leaves two edges after rst_n rises
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta  <= 1'b0;
         rstSyncN <= 1'b0;
      end else begin
         rstMeta  <= 1'b1;
         rstSyncN <= rstMeta;
      end
   end

   // detectors share this clock, so their flags are taken without sync
   lfs_flag_track #(.WIDTH(LINE_HIGH_N)) u_line_high (
      .clk      (clk),
      .rstSyncN (rstSyncN),
      .flags    (lineShortFlags[LINE_N-1:LINE_LOW_N]),
      .mirror   (lineMirror[LINE_N-1:LINE_LOW_N]),
      .newFault (faultEvent[IRQ_LINE_HIGH])
   );

   lfs_flag_track #(.WIDTH(LINE_LOW_N)) u_line_low (
      .clk      (clk),
      .rstSyncN (rstSyncN),
      .flags    (lineShortFlags[LINE_LOW_N-1:0]),
      .mirror   (lineMirror[LINE_LOW_N-1:0]),
      .newFault (faultEvent[IRQ_LINE_LOW])
   );

   lfs_flag_track #(.WIDTH(CH_N)) u_open (
      .clk      (clk),
      .rstSyncN (rstSyncN),
      .flags    (channelOpenFlags),
      .mirror   (openMirror),
      .newFault (faultEvent[IRQ_OPEN])
   );

   lfs_flag_track #(.WIDTH(CH_N)) u_short (
      .clk      (clk),
      .rstSyncN (rstSyncN),
      .flags    (channelShortFlags),
      .mirror   (shortMirror),
      .newFault (faultEvent[IRQ_SHORT])
   );

   assign setupPhase = psel & ~penable;
   assign accessDone = psel & penable;
   assign pready     = 1'b1;
   assign statusRead = accessDone & ~pwrite & (paddr == ADDR_IRQ_STATUS);

   // read mux; the 48-bit values split into a low word and a high word
   always_comb begin
      rdValue = DATA_RESET;
      addrHit = 1'b1;
      if (paddr == ADDR_LINE_HIGH) begin
         rdValue[HI_W-1:0] = lineMirror[LINE_N-1:LINE_LOW_N];
      end else if (paddr == ADDR_LINE_LOW_LO) begin
         rdValue = lineMirror[LO_W-1:0];
      end else if (paddr == ADDR_LINE_LOW_HI) begin
         rdValue[HI_W-1:0] = lineMirror[LINE_LOW_N-1:LO_W];
      end else if (paddr == ADDR_OPEN_LO) begin
         rdValue = openMirror[LO_W-1:0];
      end else if (paddr == ADDR_OPEN_HI) begin
         rdValue[HI_W-1:0] = openMirror[CH_N-1:LO_W];
      end else if (paddr == ADDR_SHORT_LO) begin
         rdValue = shortMirror[LO_W-1:0];
      end else if (paddr == ADDR_SHORT_HI) begin
         rdValue[HI_W-1:0] = shortMirror[CH_N-1:LO_W];
      end else if (paddr == ADDR_IRQ_STATUS) begin
         rdValue[IRQ_W-1:0] = irqStatus;
      end else if (paddr == ADDR_IRQ_MASK) begin
         rdValue[IRQ_W-1:0] = irqMask;
      end else if (paddr == ADDR_LINE_SELECT) begin
         rdValue[SEL_W-1:0] = shortLineSelect;
      end else begin
         addrHit = 1'b0;
      end
   end

   // read data is frozen at setup so it cannot shift during the access
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         prdata <= DATA_RESET;
      end else if (setupPhase && !pwrite) begin
         prdata <= rdValue;
      end
   end

   assign pslverr = accessDone & ~addrHit;

   // only the bits actually returned are cleared; later events survive
   assign statusClear = statusRead ? prdata[IRQ_W-1:0] : IRQ_RESET;

   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         irqStatus <= IRQ_RESET;
      end else begin
         irqStatus <= (irqStatus & ~statusClear) | faultEvent;
      end
   end

   // fault words take no write path at all, so writes there are dropped
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         irqMask <= IRQ_RESET;
      end else if (accessDone && pwrite && paddr == ADDR_IRQ_MASK) begin
         irqMask <= pwdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         shortLineSelect <= SEL_RESET;
      end else if (accessDone && pwrite && paddr == ADDR_LINE_SELECT) begin
         shortLineSelect <= pwdata[SEL_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irqStatus & irqMask);
      end
   end

   chk_line_high_read : assert property (
      @(posedge clk) disable iff (!rstSyncN)
      (setupPhase && !pwrite && paddr == ADDR_LINE_HIGH)
      |=> prdata[HI_W-1:0] == $past(lineShortFlags[LINE_N-1:LINE_LOW_N], 2))
      else $error("upper line short word does not match lines 48 to 63");

   chk_line_low_read : assert property (
      @(posedge clk) disable iff (!rstSyncN)
      (setupPhase && !pwrite && paddr == ADDR_LINE_LOW_LO)
      |=> prdata == $past(lineShortFlags[LO_W-1:0], 2))
      else $error("lower line short word does not match lines 0 to 31");

   chk_line_low_high : assert property (
      @(posedge clk) disable iff (!rstSyncN)
      (setupPhase && !pwrite && paddr == ADDR_LINE_LOW_HI)
      |=> prdata[HI_W-1:0] == $past(lineShortFlags[LINE_LOW_N-1:LO_W], 2))
      else $error("line short word does not match lines 32 to 47");

   chk_open_read : assert property (
      @(posedge clk) disable iff (!rstSyncN)
      (setupPhase && !pwrite && paddr == ADDR_OPEN_HI)
      |=> prdata == {16'h0000, $past(channelOpenFlags[CH_N-1:LO_W], 2)})
      else $error("open fault upper word does not match channels 32 to 47");

   chk_short_read : assert property (
      @(posedge clk) disable iff (!rstSyncN)
      (setupPhase && !pwrite && paddr == ADDR_SHORT_LO)
      |=> prdata == $past(channelShortFlags[LO_W-1:0], 2))
      else $error("short fault lower word does not match channels 0 to 31");

   chk_upper_zero : assert property (
      @(posedge clk) disable iff (!rstSyncN)
      (setupPhase && !pwrite && paddr == ADDR_LINE_HIGH)
      |=> prdata[DATA_W-1:HI_W] == 16'h0000 && !pslverr)
      else $error("unused upper bits of upper line word are not zero");

   chk_write_ignored : assert property (
      @(posedge clk) disable iff (!rstSyncN)
      (accessDone && pwrite && paddr <= ADDR_SHORT_HI)
      |=> $stable(shortLineSelect) && $stable(irqMask))
      else $error("write to a fault word altered another register");

   chk_line_select : assert property (
      @(posedge clk) disable iff (!rstSyncN)
      (accessDone && pwrite && paddr == ADDR_LINE_SELECT)
      |=> shortLineSelect == $past(pwdata[SEL_W-1:0]))
      else $error("line select did not take the written number");

   chk_irq_level : assert property (
      @(posedge clk) disable iff (!rstSyncN)
      irq == |$past(irqStatus & irqMask))
      else $error("interrupt line does not follow unmasked status");

   // a read clears only what it returned, and a new event still wins
   chk_status_clear : assert property (
      @(posedge clk) disable iff (!rstSyncN)
      statusRead
      |=> (irqStatus & $past(prdata[IRQ_W-1:0] & ~faultEvent)) == IRQ_RESET)
      else $error("status bits returned by a read were not cleared");

   chk_status_set : assert property (
      @(posedge clk) disable iff (!rstSyncN)
      faultEvent != IRQ_RESET
      |=> (irqStatus & $past(faultEvent)) == $past(faultEvent))
      else $error("new fault event did not set its status bit");
endmodule // lfs_fault_regs

// ### testbench/lfs_ctrl_model.sv
`timescale 1ns/1ps
// register master standing in for the display controller
module lfs_ctrl_model
   import lfs_pkg::*;
(
   input  wire logic                       clk,
   output logic                            psel,
   output logic                            penable,
   output logic                            pwrite,
   output logic [lfs_pkg::ADDR_W-1:0]      paddr,
   output logic [lfs_pkg::DATA_W-1:0]      pwdata,
   input  wire logic [lfs_pkg::DATA_W-1:0] prdata,
   input  wire logic                       pready,
   input  wire logic                       pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // line select writes carry the line number in bits 5:0
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // released lines scramble so a stale value never looks valid
      paddr   <= ~a;
      pwdata  <= ~d;
   endtask
endmodule // lfs_ctrl_model

// ### testbench/tb_lfs_fault_regs.sv
`timescale 1ns/1ps
module tb_lfs_fault_regs;
   import lfs_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [63:0] lineF = 64'h0;
   logic [47:0] openF = 48'h0;
   logic [47:0] shortF = 48'h0;
   logic        psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic [5:0]  sel;
   logic        e;
   int          failures = 0;
   int          checksDone = 0;
   int          cycles = 0;
   logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
   logic [31:0] re [7] = '{32'h0000_8003, 32'h0f0f_3c3c, 32'h0000_a5a5,
      32'h1234_5671, 32'h0000_8000, 32'h8765_0001, 32'h0000_4321};

   always #20 clk = ~clk;

   lfs_fault_regs dut (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .lineShortFlags(lineF), .channelOpenFlags(openF),
      .channelShortFlags(shortF), .shortLineSelect(sel), .irq(irq));
   lfs_ctrl_model u (.clk(clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));

   task conclude;
      if (failures == 0 && checksDone > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task chk(input logic [31:0] s, input logic [31:0] x);
      checksDone++;
      if (s !== x) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask

   task rd(input logic [7:0] a, input logic [31:0] x);
      u.xfer(1'b0, a, 32'h0, q, e);
      chk(q, x);
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         failures++;
         conclude;
      end
   end

   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      u.xfer(1'b1, ADDR_IRQ_MASK, 32'h1, q, e);
      @(posedge clk);
      // upper word not bit-symmetric, so a reversed line order shows up
      lineF <= 64'h8003_a5a5_0f0f_3c3c;
      openF <= 48'h8000_1234_5671;
      shortF <= 48'h4321_8765_0001;
      repeat (4) @(posedge clk);
      #1 chk({31'h0, irq}, 32'h1);
      rd(ADDR_IRQ_STATUS, 32'hf);
      repeat (3) @(posedge clk);
      #1 chk({31'h0, irq}, 32'h0);
      for (int i = 0; i < 7; i++) rd(ra[i], re[i]);
      // a write to a fault word must leave it mirroring the detector
      u.xfer(1'b1, ADDR_LINE_LOW_LO, 32'hffff_ffff, q, e);
      chk({31'h0, e}, 32'h0);
      rd(ADDR_LINE_LOW_LO, re[1]);
      rd(ADDR_LINE_HIGH, re[0]);
      // masked open-load event latches status but keeps irq low
      @(posedge clk);
      openF <= 48'h0;
      repeat (2) @(posedge clk);
      openF <= 48'h8000_1234_5671;
      repeat (4) @(posedge clk);
      #1 chk({31'h0, irq}, 32'h0);
      rd(ADDR_IRQ_STATUS, 32'h4);
      rd(ADDR_IRQ_MASK, 32'h1);
      u.xfer(1'b1, ADDR_LINE_SELECT, 32'hffff_ffff, q, e);
      #1 chk({26'h0, sel}, 32'h3f);
      rd(ADDR_LINE_SELECT, 32'h3f);
      u.xfer(1'b1, ADDR_LINE_SELECT, 32'h20, q, e);
      rd(ADDR_LINE_SELECT, 32'h20);
      u.xfer(1'b0, 8'h40, 32'h0, q, e);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
      // reset in mid-run clears the writable registers
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      #1 chk({26'h0, sel}, 32'h0);
      chk({31'h0, irq}, 32'h0);
      @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd(ADDR_LINE_SELECT, 32'h0);
      rd(ADDR_IRQ_MASK, 32'h0);
      rd(ADDR_SHORT_HI, re[6]);
      conclude;
   end
endmodule // tb_lfs_fault_regs
